// file: design/flash_self_program_control.sv
/*
  Flash self-programming controller: control register, command windows, lock and fuse
  reads, signature reads, timed erase/write/lock operations and the application-section
  read block. Assumes an AXI4-Lite master that keeps one write and one read in flight,
  and a flash array that honours app_read_block.
*/
// How it works
// - Application section reads blocked while erase or page write runs.
// - Busy flag stays high while the application section is occupied.
// - Reenable request clears the busy flag; software must issue it first.
// - Lock write: data, command pattern, then store within four cycles.
// - Zero bits 5..0 of source data program matching lock bits.
// - Whole flash stays readable while lock bits are programmed.
// - EEPROM write blocks programming requests and fuse or lock reads.
// - Load at address 0x0001 within three cycles returns the lock byte.
// - Lock bits auto-clear on read or store timeout.
// - With both bits clear, load returns ordinary program memory.
// - Load at address 0x0000 in lock-read window returns fuse low byte.
// - Load at address 0x0003 returns full fuse high byte.
// - Load at address 0x0002 returns extended fuse, bits 2..0 meaningful.
// - Programmed fuse and lock bits read zero, unprogrammed read one.
// - Signature window returns signature byte; bits clear on load or timeout.
// - Signature ids at 0,2,4; calibration at 1,3; others reserved.
// - A flash write in progress completes across a reset.
// - Each operation lasts OP_COUNT oscillator ticks, by default 925000 (3.7 ms of 250 MHz cycles).
// - Enabled interrupt stays asserted while the enable bit reads zero.
module flash_self_program_control
  import selfprog_pkg::*;
#(
  parameter int unsigned OP_COUNT = OP_CYCLES,
  parameter logic [7:0] SIG_ID1 = 8'h5A,
  parameter logic [7:0] SIG_ID2 = 8'h5B,
  parameter logic [7:0] SIG_ID3 = 8'h5C,
  parameter logic [7:0] CAL_3V = 8'h80,
  parameter logic [7:0] CAL_5V = 8'h81
) (
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write channels.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels.
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Oscillator tick, EEPROM status and flash array side.
  input wire logic osc_tick,
  input wire logic eeprom_write_busy,
  input wire logic [7:0] flash_rdata,
  output logic app_read_block,
  output logic spm_irq
);
  // Identification parameters above carry arbitrary values.

  logic [6:0] selfprog_control_reg;
  logic [7:0] source_data_reg;
  logic [15:0] address_pointer;
  logic [7:0] result_byte;
  logic [7:0] lock_bits;
  logic [7:0] fuse_low_byte;
  logic [7:0] fuse_high_byte;
  logic [7:0] ext_fuse_byte;
  logic irq_enable;
  logic app_section_busy_flag;
  logic [2:0] window_cnt;
  logic [31:0] op_cnt;
  logic op_lock;
  logic [7:0] op_lock_value;
  logic ee_s1;
  logic ee_s2;
  logic osc_s1;
  logic osc_s2;
  logic osc_d;
  logic osc_pulse;

  // One-hot states of the timed flash operation.
  typedef enum logic [2:0] {
    OP_IDLE = 3'b001,
    OP_RUN = 3'b010,
    OP_DONE = 3'b100
  } op_state_t;
  op_state_t op_state;

  wr_req_t wr_req;
  logic aw_held;
  logic w_held;
  logic wr_fire;
  logic [1:0] wr_resp;
  logic instr_write;
  logic [1:0] instr_kind;

  // The EEPROM busy level passes two flops before any logic reads it.
  always_ff @(posedge aclk) begin
    ee_s1 <= eeprom_write_busy;
    ee_s2 <= ee_s1;
  end

  // The oscillator tick passes two flops; the third flop only feeds the edge detector.
  always_ff @(posedge aclk) begin
    osc_s1 <= osc_tick;
    osc_s2 <= osc_s1;
    osc_d <= osc_s2;
  end

  assign osc_pulse = osc_s2 & ~osc_d;

  // Bit 5 is compared on its own so a signature command never matches a lock command.
  function automatic logic is_cmd(input logic [6:0] ctrl, input logic [6:0] cmd);
    return (ctrl & CMD_MASK) == (cmd & CMD_MASK) && ctrl[BIT_SIG_READ] == cmd[BIT_SIG_READ];
  endfunction

  function automatic logic is_mapped(input logic [7:0] addr);
    return addr == OFF_CTRL || addr == OFF_SRC || addr == OFF_ADDR || addr == OFF_INSTR ||
      addr == OFF_RESULT || addr == OFF_EEPROM || addr == OFF_FUSE || addr == OFF_LOCK ||
      addr == OFF_INTEN;
  endfunction

  // Write address and data are taken in either order; the response follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_req <= '0;
    end else begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        wr_req.addr <= awaddr;
      end
      if (wvalid && wready) begin
        w_held <= 1'b1;
        wr_req.data <= wdata;
        wr_req.strb <= wstrb;
      end
      if (wr_fire) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
      end
    end
  end

  assign awready = ~aw_held & ~bvalid;
  assign wready = ~w_held & ~bvalid;
  assign wr_fire = aw_held & w_held;
  // The instruction register stands in for the core's load and store instructions.
  assign instr_write = wr_fire && wr_req.addr == OFF_INSTR && wr_req.strb[0];
  assign instr_kind = instr_write ? wr_req.data[1:0] : 2'b00;

  // A refused control write still gets a response so the master never stalls.
  always_comb begin
    wr_resp = RESP_OKAY;
    if (!is_mapped(wr_req.addr)) begin
      wr_resp = RESP_DECERR;
    end else if (wr_req.addr == OFF_CTRL && ee_s2) begin
      wr_resp = RESP_SLVERR;
    end
  end

  // The write response stands until the master shows bready.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp <= wr_resp;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Plain data registers written by software.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      source_data_reg <= '0;
      address_pointer <= '0;
      irq_enable <= 1'b0;
      fuse_low_byte <= LOCK_RESET;
      fuse_high_byte <= LOCK_RESET;
      ext_fuse_byte <= LOCK_RESET;
    end else if (wr_fire && wr_req.strb[0]) begin
      unique case (wr_req.addr)
        OFF_SRC: source_data_reg <= wr_req.data[7:0];
        OFF_ADDR: address_pointer <= wr_req.data[15:0];
        OFF_INTEN: irq_enable <= wr_req.data[0];
        // The fuse word is a test-loading path; unused extended bits read as unprogrammed.
        OFF_FUSE: begin
          fuse_low_byte <= wr_req.data[7:0];
          fuse_high_byte <= wr_req.data[15:8];
          ext_fuse_byte <= wr_req.data[23:16] | ~EXT_FUSE_MASK;
        end
        default: begin
        end
      endcase
    end
  end

  // Control register, command window and instruction handling.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      selfprog_control_reg <= '0;
      window_cnt <= '0;
      result_byte <= '0;
    end else begin
      if (wr_fire && wr_req.addr == OFF_CTRL && wr_req.strb[0] && !ee_s2) begin
        selfprog_control_reg <= wr_req.data[6:0] & CMD_MASK | (wr_req.data[6:0] & 7'h20);
        window_cnt <= 3'(STORE_WINDOW);
      end else if (selfprog_control_reg[BIT_ENABLE] && op_state == OP_IDLE) begin
        // The countdown runs only while the enable bit is set and no operation runs.
        if (instr_kind == INSTR_LOAD && window_cnt > 3'(STORE_WINDOW - LOAD_WINDOW)) begin
          if (is_cmd(selfprog_control_reg, CMD_LOCK_READ) && !ee_s2) begin
            unique case (address_pointer)
              ADDR_LOCK: result_byte <= lock_bits;
              ADDR_FUSE_LOW: result_byte <= fuse_low_byte;
              ADDR_FUSE_HIGH: result_byte <= fuse_high_byte;
              ADDR_EXT_FUSE: result_byte <= ext_fuse_byte;
              default: result_byte <= LOCK_RESET;
            endcase
            selfprog_control_reg <= '0;
          end else if (is_cmd(selfprog_control_reg, CMD_SIG_READ)) begin
            unique case (address_pointer)
              ADDR_SIG_ID1: result_byte <= SIG_ID1;
              ADDR_SIG_ID2: result_byte <= SIG_ID2;
              ADDR_SIG_ID3: result_byte <= SIG_ID3;
              ADDR_SIG_CAL3: result_byte <= CAL_3V;
              ADDR_SIG_CAL5: result_byte <= CAL_5V;
              default: result_byte <= '0;
            endcase
            selfprog_control_reg <= '0;
          end else begin
            result_byte <= app_read_block ? '0 : flash_rdata;
          end
        end else if (instr_kind == INSTR_STORE) begin
          // Operation start clears the window; the enable bit stays set until done.
          selfprog_control_reg[BIT_REENABLE] <= 1'b0;
          window_cnt <= '0;
        end else if (window_cnt != '0) begin
          window_cnt <= window_cnt - 3'd1;
          if (window_cnt == 3'(STORE_WINDOW - LOAD_WINDOW + 1) &&
              is_cmd(selfprog_control_reg, CMD_SIG_READ)) begin
            selfprog_control_reg <= '0;
          end
        end else begin
          // An expired window drops the whole command, so a late load reads the array.
          selfprog_control_reg <= '0;
        end
      end else if (instr_kind == INSTR_LOAD) begin
        result_byte <= app_read_block ? '0 : flash_rdata;
      end
      // Completion clears the command bits, which raises the interrupt level when enabled.
      if (op_state == OP_DONE) begin
        selfprog_control_reg[BIT_ENABLE] <= 1'b0;
        selfprog_control_reg[BIT_PAGE_ERASE] <= 1'b0;
        selfprog_control_reg[BIT_PAGE_WRITE] <= 1'b0;
        selfprog_control_reg[BIT_LOCK_SET] <= 1'b0;
      end
    end
  end

  // Busy flag for the application section; it survives a reset while an operation runs.
  always_ff @(posedge aclk) begin
    if (!aresetn && op_state != OP_RUN) begin
      app_section_busy_flag <= 1'b0;
    end else if (op_state == OP_RUN && !op_lock) begin
      app_section_busy_flag <= 1'b1;
    end else if (aresetn && instr_kind == INSTR_STORE && is_cmd(selfprog_control_reg, CMD_REENABLE) &&
                 window_cnt != '0) begin
      app_section_busy_flag <= 1'b0;
    end
  end

  // Timed operation; the sequencer ignores reset while running so a write completes.
  always_ff @(posedge aclk) begin
    if (!aresetn && op_state != OP_RUN) begin
      op_state <= OP_IDLE;
      op_cnt <= '0;
      op_lock <= 1'b0;
      op_lock_value <= '0;
    end else begin
      unique case (op_state)
        OP_IDLE: begin
          if (aresetn && instr_kind == INSTR_STORE && window_cnt != '0 && !ee_s2 &&
              (is_cmd(selfprog_control_reg, CMD_ERASE) || is_cmd(selfprog_control_reg, CMD_WRITE) ||
               is_cmd(selfprog_control_reg, CMD_LOCK_WRITE))) begin
            op_state <= OP_RUN;
            op_cnt <= OP_COUNT;
            op_lock <= is_cmd(selfprog_control_reg, CMD_LOCK_WRITE);
            // Bits 7 and 6 are kept unprogrammed whatever the source byte holds.
            op_lock_value <= {2'b11, source_data_reg[5:0]};
          end
        end
        OP_RUN: begin
          if (osc_pulse) begin
            op_cnt <= op_cnt - 32'd1;
            if (op_cnt == 32'd1) begin
              op_state <= OP_DONE;
            end
          end
        end
        OP_DONE: begin
          op_state <= OP_IDLE;
        end
        default: op_state <= OP_IDLE;
      endcase
    end
  end

  // Between resets, lock bits only move towards programmed.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_bits <= LOCK_RESET;
    end else if (op_state == OP_DONE && op_lock) begin
      lock_bits <= lock_bits & op_lock_value;
    end
  end

  // Lock programming never sets the busy flag, so the whole array stays readable.
  assign app_read_block = app_section_busy_flag;
  assign spm_irq = irq_enable & ~selfprog_control_reg[BIT_ENABLE];

  // Read channel.
  // Reads answer one cycle after the address; arready stays low while a response stands.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rresp <= is_mapped(araddr) ? RESP_OKAY : RESP_DECERR;
      unique case (araddr)
        OFF_CTRL: rdata <= {24'h0000_00, 1'b0, app_section_busy_flag, selfprog_control_reg[5:0]};
        OFF_SRC: rdata <= {24'h0000_00, source_data_reg};
        OFF_ADDR: rdata <= {16'h0000, address_pointer};
        OFF_RESULT: rdata <= {24'h0000_00, result_byte};
        OFF_EEPROM: rdata <= {31'h0000_0000, ee_s2};
        OFF_FUSE: rdata <= {8'h00, ext_fuse_byte, fuse_high_byte, fuse_low_byte};
        OFF_LOCK: rdata <= {24'h0000_00, lock_bits};
        OFF_INTEN: rdata <= {31'h0000_0000, irq_enable};
        default: rdata <= '0;
      endcase
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  assign arready = ~rvalid;
endmodule

// file: design/selfprog_pkg.sv
/*
  Constants, register map and carrier types for the flash self-programming controller.
  Assumes a 250 MHz system clock and an AXI4-Lite register bus with 32-bit data.
*/
package selfprog_pkg;
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned OP_MIN_US = 3700;
  localparam int unsigned OP_MAX_US = 4500;
  localparam int unsigned OP_CYCLES = OP_MIN_US * CLK_MHZ;
  localparam int unsigned OP_MAX_CYCLES = OP_MAX_US * CLK_MHZ;
  localparam int unsigned LOAD_WINDOW = 3;
  localparam int unsigned STORE_WINDOW = 4;
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_SRC = 8'h04;
  localparam logic [7:0] OFF_ADDR = 8'h08;
  localparam logic [7:0] OFF_INSTR = 8'h0C;
  localparam logic [7:0] OFF_RESULT = 8'h10;
  localparam logic [7:0] OFF_EEPROM = 8'h14;
  localparam logic [7:0] OFF_FUSE = 8'h18;
  localparam logic [7:0] OFF_LOCK = 8'h1C;
  localparam logic [7:0] OFF_INTEN = 8'h20;
  localparam int unsigned BIT_ENABLE = 0;
  localparam int unsigned BIT_PAGE_ERASE = 1;
  localparam int unsigned BIT_PAGE_WRITE = 2;
  localparam int unsigned BIT_LOCK_SET = 3;
  localparam int unsigned BIT_REENABLE = 4;
  localparam int unsigned BIT_SIG_READ = 5;
  localparam int unsigned BIT_BUSY = 6;
  localparam logic [6:0] CMD_MASK = 7'h3F;
  localparam logic [6:0] CMD_LOCK_WRITE = 7'h09;
  localparam logic [6:0] CMD_ERASE = 7'h03;
  localparam logic [6:0] CMD_WRITE = 7'h05;
  localparam logic [6:0] CMD_LOCK_READ = 7'h09;
  localparam logic [6:0] CMD_SIG_READ = 7'h21;
  localparam logic [6:0] CMD_REENABLE = 7'h11;
  localparam logic [15:0] ADDR_FUSE_LOW = 16'h0000;
  localparam logic [15:0] ADDR_LOCK = 16'h0001;
  localparam logic [15:0] ADDR_EXT_FUSE = 16'h0002;
  localparam logic [15:0] ADDR_FUSE_HIGH = 16'h0003;
  localparam logic [15:0] ADDR_SIG_ID1 = 16'h0000;
  localparam logic [15:0] ADDR_SIG_CAL3 = 16'h0001;
  localparam logic [15:0] ADDR_SIG_ID2 = 16'h0002;
  localparam logic [15:0] ADDR_SIG_CAL5 = 16'h0003;
  localparam logic [15:0] ADDR_SIG_ID3 = 16'h0004;
  localparam logic [7:0] LOCK_RESET = 8'hFF;
  localparam logic [5:0] LOCK_FIELD = 6'h3F;
  localparam logic [7:0] EXT_FUSE_MASK = 8'h07;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  localparam logic [1:0] RESP_DECERR = 2'b11;
  localparam logic [1:0] INSTR_LOAD = 2'b01;
  localparam logic [1:0] INSTR_STORE = 2'b10;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
  } wr_req_t;

  typedef struct packed {
    logic [7:0] lock;
    logic [7:0] fuse_low;
    logic [7:0] fuse_high;
    logic [7:0] ext_fuse;
  } nv_bytes_t;
endpackage

// file: verif/flash_side_model.sv
/*
  Flash array and RC oscillator beside the self-programming controller.
  Assumes the bench clock also clocks the array read port.
*/
module flash_side_model #(
  parameter logic [7:0] ARRAY_BYTE = 8'hA5
) (
  // Array side.
  input wire logic aclk,
  input wire logic app_read_block,
  output logic [7:0] flash_rdata,
  // Oscillator.
  output logic osc_tick
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    osc_tick = 1'b0;
    forever begin
      #130 osc_tick = 1'b1;
      #20 osc_tick = 1'b0;
    end
  end

  // A blocked section never shows stable data.
  always @(posedge aclk) begin
    flash_rdata <= app_read_block ? ~flash_rdata : ARRAY_BYTE;
  end
endmodule

// file: verif/selfprog_checker.sv
/*
  Port checker for the flash self-programming controller.
  Assumes it is bound to every instance of that module and sees only its ports.
*/
module selfprog_checker
  import selfprog_pkg::*;
(
  // Clock and reset.
  input wire logic aclk,
  input wire logic aresetn,
  // Write side.
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  // Read side.
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  // Status.
  input wire logic eeprom_write_busy,
  input wire logic app_read_block
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  sequence s_wr_taken;
    awvalid && awready;
  endsequence
  sequence s_ee_busy;
    eeprom_write_busy [*4];
  endsequence
  property p_ee_refuse;
    s_ee_busy ##0 s_wr_taken ##0 awaddr == OFF_CTRL |-> ##[1:3] bvalid && bresp == RESP_SLVERR;
  endproperty
  property p_block_thru_reset;
    @(posedge aclk) disable iff (1'b0) $fell(aresetn) && app_read_block |=> app_read_block;
  endproperty

  a_b_holds: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");
  a_r_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read response dropped early");
  a_resp_follows: assert property (s_wr_taken |-> ##[1:3] bvalid)
    else $error("write response missing");
  a_read_answer: assert property (arvalid && arready |=> rvalid)
    else $error("read answer late");
  a_read_decerr: assert property (arvalid && arready && araddr > OFF_INTEN |=> rresp == RESP_DECERR)
    else $error("unmapped read not refused");
  a_write_decerr: assert property (s_wr_taken ##0 awaddr > OFF_INTEN |-> ##[1:3] bvalid && bresp == RESP_DECERR)
    else $error("unmapped write not refused");
  a_ee_refuse: assert property (p_ee_refuse)
    else $error("control write taken during eeprom write");
  a_src_okay: assert property (s_wr_taken ##0 awaddr == OFF_SRC |-> ##[1:3] bvalid && bresp == RESP_OKAY)
    else $error("mapped write refused");
  a_block_kept: assert property (p_block_thru_reset)
    else $error("read block lost at reset");
endmodule

bind flash_self_program_control selfprog_checker chk (.aclk, .aresetn, .awaddr, .awvalid, .awready, .bresp,
  .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .eeprom_write_busy,
  .app_read_block);

// file: verif/tb_top.sv
/*
  Self-checking bench for the flash self-programming controller.
  Assumes the flash side model drives the oscillator tick and the array byte.
*/
module tb_top import selfprog_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] ARRAY_BYTE = 8'hA5;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, osc_tick, eeprom_write_busy;
  logic awready, wready, bvalid, arready, rvalid, app_read_block, spm_irq, blk;
  logic [7:0] awaddr, araddr, flash_rdata;
  logic [31:0] wdata, rdata, rd_val;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  int failures, n_tests, cyc;
  logic [7:0] sig_tab [5] = '{8'h11, 8'h44, 8'h22, 8'h55, 8'h33};
  logic [7:0] nv_tab [4] = '{8'hE2, 8'hFF, 8'hFD, 8'h3C};
  logic [7:0] msk [4] = '{8'hFF, 8'h3F, 8'h07, 8'hFF};

  // Signature and calibration values are arbitrary.
  flash_self_program_control #(.OP_COUNT(4), .SIG_ID1(8'h11), .SIG_ID2(8'h22), .SIG_ID3(8'h33),
    .CAL_3V(8'h44), .CAL_5V(8'h55)) dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .osc_tick, .eeprom_write_busy, .flash_rdata, .app_read_block, .spm_irq);
  flash_side_model #(.ARRAY_BYTE(ARRAY_BYTE)) model (.aclk, .app_read_block, .flash_rdata, .osc_tick);

  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    logic ta, tw, tb;
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      resp = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      bready <= !tb;
      n++;
    end while (!tb && n < 100);
    if (!tb) failures++;
  endtask

  task automatic rd(input logic [7:0] a);
    logic ta, tr;
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid && rready;
      rd_val = rdata;
      resp = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      rready <= !tr;
      n++;
    end while (!tr && n < 100);
    if (!tr) failures++;
  endtask

  task automatic cmd(input logic [6:0] c, input logic [1:0] op);
    wr(OFF_CTRL, 32'(c));
    wr(OFF_INSTR, 32'(op));
  endtask

  task automatic wait_done();
    time t0;
    t0 = $time;
    blk = 1'b0;
    do begin
      blk |= app_read_block;
      rd(OFF_CTRL);
    end while (rd_val[BIT_ENABLE] === 1'b1 && $time - t0 < 4000);
    if (rd_val[BIT_ENABLE] !== 1'b0) failures++;
    cyc = int'(($time - t0) / 4);
  endtask

  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  initial begin
    #40000;
    failures++;
    print_verdict();
  end

  initial begin
    {aresetn, awvalid, wvalid, arvalid, eeprom_write_busy, awaddr, araddr, wdata} = '0;
    {bready, rready} = '0;
    wstrb = '1;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    wr(OFF_LOCK, 32'h0000_0000);
    rd(OFF_LOCK);
    check("lock reset", rd_val[7:0], LOCK_RESET);
    rd(8'h40);
    check("unmapped read", 8'(resp), 8'(RESP_DECERR));
    wr(8'h44, 32'h0000_0001);
    check("unmapped write", 8'(resp), 8'(RESP_DECERR));
    wr(OFF_FUSE, 32'h00FD_3CE2);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_ADDR, 32'(i));
      cmd(CMD_LOCK_READ, INSTR_LOAD);
      rd(OFF_RESULT);
      check("fuse or lock byte", rd_val[7:0] & msk[i], nv_tab[i] & msk[i]);
      rd(OFF_CTRL);
      check("window after load", rd_val[7:0] & 8'h3F, 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      wr(OFF_ADDR, 32'(i));
      cmd(CMD_SIG_READ, INSTR_LOAD);
      rd(OFF_RESULT);
      check("signature byte", rd_val[7:0], sig_tab[i]);
    end
    wr(OFF_CTRL, 32'(CMD_LOCK_READ));
    repeat (8) @(posedge aclk);
    rd(OFF_CTRL);
    check("window expired", rd_val[7:0] & 8'h3F, 8'h00);
    wr(OFF_INSTR, 32'(INSTR_LOAD));
    rd(OFF_RESULT);
    check("plain load", rd_val[7:0], ARRAY_BYTE);
    wr(OFF_SRC, 32'h0000_00F2);
    wr(OFF_SRC, 32'h0000_0000, 4'h0);
    rd(OFF_SRC);
    check("masked source write", rd_val[7:0], 8'hF2);
    wr(OFF_ADDR, 32'h0000_0001);
    cmd(CMD_LOCK_WRITE, INSTR_STORE);
    wait_done();
    check("block in lock write", 8'(blk), 8'h00);
    check("lock write time", 8'(cyc > 100 && cyc < 230), 8'h01);
    rd(OFF_LOCK);
    check("lock bits", rd_val[7:0] & 8'h3F, 8'h32);
    eeprom_write_busy <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(OFF_EEPROM);
    check("eeprom status", rd_val[7:0], 8'h01);
    wr(OFF_CTRL, 32'(CMD_ERASE));
    check("control refused", 8'(resp), 8'(RESP_SLVERR));
    wr(OFF_INSTR, 32'(INSTR_STORE));
    @(negedge aclk);
    check("no erase", 8'(app_read_block), 8'h00);
    eeprom_write_busy <= 1'b0;
    repeat (4) @(posedge aclk);
    wr(OFF_INTEN, 32'h0000_0001);
    check("irq idle", 8'(spm_irq), 8'h01);
    for (int k = 0; k < 2; k++) begin
      cmd(k ? CMD_WRITE : CMD_ERASE, INSTR_STORE);
      @(negedge aclk);
      check("irq running", 8'(spm_irq), 8'h00);
      wait_done();
      check("block running", 8'(blk), 8'h01);
      check("operation time", 8'(cyc > 100 && cyc < 230), 8'h01);
      check("busy after done", 8'(rd_val[BIT_BUSY]), 8'h01);
      check("irq done", 8'(spm_irq), 8'h01);
      cmd(CMD_REENABLE, INSTR_STORE);
      rd(OFF_CTRL);
      check("busy cleared", 8'(rd_val[BIT_BUSY]), 8'h00);
      check("block released", 8'(app_read_block), 8'h00);
    end
    cmd(CMD_WRITE, INSTR_STORE);
    repeat (20) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    check("write survives reset", 8'(app_read_block), 8'h01);
    repeat (250) @(posedge aclk);
    cmd(CMD_REENABLE, INSTR_STORE);
    @(negedge aclk);
    check("block after reset write", 8'(app_read_block), 8'h00);
    print_verdict();
  end
endmodule
